// [shared/ssd_pkg.sv]
/*
 * Constants and types for the special register space decoder: region
 * bounds, register offsets, reset values and access attributes.
 * Assumes a 16-bit data address bus and 8-bit special registers.
 */
package ssd_pkg;

   // ****************************************************************
   // Region and slot geometry
   // ****************************************************************
   localparam logic [7:0] SSD_REGION_PAGE = 8'hFF;
   localparam logic [15:0] SSD_REGION_BASE = 16'hFF00;
   localparam logic [15:0] SSD_REGION_LAST = 16'hFFFF;
   localparam int SSD_SLOTS = 50;
   localparam int SSD_SLOT_W = 6;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [15:0] SSD_OFS_PORT_DATA_0 = 16'hFF00;
   localparam logic [15:0] SSD_OFS_PORT_DATA_1 = 16'hFF01;
   localparam logic [15:0] SSD_OFS_USB_CTRL_EP_READ_FIFO = 16'hFF02;
   localparam logic [15:0] SSD_OFS_PORT_DATA_3 = 16'hFF03;
   localparam logic [15:0] SSD_OFS_PORT_DATA_6 = 16'hFF06;
   localparam logic [15:0] SSD_OFS_UART_RECEIVE_BUFFER = 16'hFF0A;
   localparam logic [15:0] SSD_OFS_UART_TRANSMIT_BUFFER = 16'hFF0B;
   localparam logic [15:0] SSD_OFS_PORT_DATA_12 = 16'hFF0C;
   localparam logic [15:0] SSD_OFS_USB_BULK_OUT_FIFO = 16'hFF0D;
   localparam logic [15:0] SSD_OFS_USB_BULK_IN_FIFO = 16'hFF0E;
   localparam logic [15:0] SSD_OFS_CLOCKED_SERIAL_SHIFT = 16'hFF0F;
   localparam logic [15:0] SSD_OFS_TIMER16_COUNT = 16'hFF10;
   localparam logic [15:0] SSD_OFS_TIMER16_CAPTURE_COMPARE_A = 16'hFF12;
   localparam logic [15:0] SSD_OFS_TIMER16_CAPTURE_COMPARE_B = 16'hFF14;
   localparam logic [15:0] SSD_OFS_TIMER8_COUNT_A = 16'hFF16;
   localparam logic [15:0] SSD_OFS_TIMER8_COMPARE_A = 16'hFF17;
   localparam logic [15:0] SSD_OFS_USB_SETUP_PACKET_READ = 16'hFF18;
   localparam logic [15:0] SSD_OFS_USB_CTRL_EP_WRITE_FIFO = 16'hFF19;
   localparam logic [15:0] SSD_OFS_TIMER_H_COMPARE_LOW = 16'hFF1A;
   localparam logic [15:0] SSD_OFS_TIMER_H_COMPARE_HIGH = 16'hFF1B;
   localparam logic [15:0] SSD_OFS_TIMER8_COUNT_B = 16'hFF1F;
   localparam logic [15:0] SSD_OFS_PORT_DIRECTION_0 = 16'hFF20;
   localparam logic [15:0] SSD_OFS_PORT_DIRECTION_1 = 16'hFF21;
   localparam logic [15:0] SSD_OFS_PORT_DIRECTION_3 = 16'hFF23;
   localparam logic [15:0] SSD_OFS_PORT_DIRECTION_6 = 16'hFF26;
   localparam logic [15:0] SSD_OFS_USB_INT_STATUS_0 = 16'hFF27;
   localparam logic [15:0] SSD_OFS_USB_INT_STATUS_1 = 16'hFF28;
   localparam logic [15:0] SSD_OFS_USB_INT_STATUS_2 = 16'hFF29;
   localparam logic [15:0] SSD_OFS_USB_INT_STATUS_3 = 16'hFF2A;
   localparam logic [15:0] SSD_OFS_USB_INT_STATUS_4 = 16'hFF2B;
   localparam logic [15:0] SSD_OFS_PORT_DIRECTION_12 = 16'hFF2C;
   localparam logic [15:0] SSD_OFS_USB_GENERAL_PURPOSE = 16'hFF2D;
   localparam logic [15:0] SSD_OFS_USB_MODE_CONTROL = 16'hFF2E;
   localparam logic [15:0] SSD_OFS_USB_MODE_FLAGS = 16'hFF2F;
   localparam logic [15:0] SSD_OFS_PULLUP_ENABLE_0 = 16'hFF30;
   localparam logic [15:0] SSD_OFS_PULLUP_ENABLE_1 = 16'hFF31;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] SSD_RST_ZERO = 8'h00;
   localparam logic [7:0] SSD_RST_DIR = 8'hFF;
   localparam logic [7:0] SSD_RST_UART = 8'hFF;
   localparam logic [15:0] SSD_RST_T16 = 16'h0000;
   localparam logic [7:0] SSD_RST_UNDEF = 8'h00;
   localparam logic [7:0] SSD_RDATA_UNSPEC = 8'h00;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {SSD_W_BIT, SSD_W_BYTE, SSD_W_WORD} ssd_width_e;

   typedef logic [SSD_SLOT_W-1:0] ssd_slot_t;

   typedef struct packed {
      logic present;
      logic rd;
      logic wr;
      logic bit_ok;
      logic byte_ok;
      logic word_ok;
      logic [7:0] rst;
   } ssd_attr_s;

endpackage

// [shared/ssd_chk_if.sv]
/*
 * Carrier between the decoder top and its access checker: the request
 * as seen by the checker, the attributes of both bytes, and the verdict.
 * Assumes both ends share one clock; all signals are combinational.
 */
`timescale 1ns/1ps
interface ssd_chk_if;
   import ssd_pkg::*;

   logic [15:0] addr;
   ssd_width_e width;
   logic write;
   ssd_attr_s attr_lo;
   ssd_attr_s attr_hi;
   logic in_region;
   logic allowed;
   ssd_slot_t slot_lo;
   ssd_slot_t slot_hi;

   // Top side asks, checker answers
   modport req (output addr, width, write, attr_lo, attr_hi,
                input in_region, allowed, slot_lo, slot_hi);
   modport chk (input addr, width, write, attr_lo, attr_hi,
                output in_region, allowed, slot_lo, slot_hi);
endinterface

// [hdl/ssd_access_check.sv]
/*
 * Access checker: judges one request against the region bounds, the
 * width set and the direction of the addressed register.
 * Assumes the top module supplies attributes for addr and addr+1.
 */
`timescale 1ns/1ps
module ssd_access_check (
   ssd_chk_if.chk chk
);
   import ssd_pkg::*;

   logic byte_in_table;
   logic width_ok;
   logic dir_ok;

   // ****************************************************************
   // Region and slot decode
   // ****************************************************************
   always_comb begin
      chk.in_region = (chk.addr[15:8] == SSD_REGION_PAGE);
      byte_in_table = chk.in_region && (chk.addr[7:0] < 8'(SSD_SLOTS));
      chk.slot_lo = chk.addr[SSD_SLOT_W-1:0];
      chk.slot_hi = SSD_SLOT_W'(chk.addr[SSD_SLOT_W-1:0] + 6'h01);
   end

   // Width set of the addressed register; words need even address
   always_comb begin
      case (chk.width)
         SSD_W_BIT: width_ok = chk.attr_lo.bit_ok;
         SSD_W_BYTE: width_ok = chk.attr_lo.byte_ok;
         SSD_W_WORD: width_ok = !chk.addr[0] && chk.attr_lo.word_ok
                               && chk.attr_hi.word_ok;
         default: width_ok = 1'b0;
      endcase
   end

   // Direction of the register against the request
   always_comb begin
      dir_ok = chk.write ? chk.attr_lo.wr : chk.attr_lo.rd;
      chk.allowed = byte_in_table && chk.attr_lo.present
                    && width_ok && dir_ok;
   end
endmodule

// [hdl/ssd_top.sv]
/*
 * Special register space decoder: takes CPU accesses to FF00H-FFFFH,
 * enforces width, direction and alignment per register, holds the
 * software-written registers and reads peripheral-owned ones.
 * Assumes a CPU that issues one request pulse at a time and peripherals
 * that present their read-only bytes on periph_val continuously.
 * Refused accesses answer with cpu_err and zero data and change no byte;
 * undefined reset bytes start at zero so reads never carry unknowns.
 */
// Operation
// - Only addresses FF00H through FFFFH are decoded as special registers.
// - Each register accepts only its own widths among bit, byte, word.
// - Undefined widths are unavailable; the device refuses them.
// - Read-only registers allow only reads; write-only only writes.
// - System reset loads each register with its defined reset value.
// - Timer count and two capture registers are even word pairs, reset zero.
// - USB data windows are byte-only, undefined at reset, directional.
// - Direction registers reset to ones; data and pull-ups to zeros.
// - UART receive and transmit buffers reset to ones, byte access only.
`timescale 1ns/1ps
module ssd_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire ssd_pkg::ssd_width_e cpu_width,
   input wire logic [15:0] cpu_addr,
   input wire logic [2:0] cpu_bit,
   input wire logic [15:0] cpu_wdata,
   output logic cpu_ack,
   output logic cpu_err,
   output logic [15:0] cpu_rdata,
   input wire logic [7:0] periph_val [ssd_pkg::SSD_SLOTS],
   output logic [7:0] sfr_value [ssd_pkg::SSD_SLOTS],
   output logic [ssd_pkg::SSD_SLOTS-1:0] sfr_wr_stb,
   output logic [ssd_pkg::SSD_SLOTS-1:0] sfr_rd_stb
);
   import ssd_pkg::*;

   // ****************************************************************
   // Attribute table
   // ****************************************************************

   // Pack one attribute entry; flags are given as 0 or 1
   function automatic ssd_attr_s ssd_mk(
      input int rd,
      input int wr,
      input int bt,
      input int by,
      input int wd,
      input logic [7:0] rst
   );
      ssd_attr_s a;
      a.present = 1'b1;
      a.rd = (rd != 0);
      a.wr = (wr != 0);
      a.bit_ok = (bt != 0);
      a.byte_ok = (by != 0);
      a.word_ok = (wd != 0);
      a.rst = rst;
      return a;
   endfunction

   // Attributes of one byte address; absent bytes come back all zero
   function automatic ssd_attr_s ssd_lookup(input logic [15:0] a);
      ssd_attr_s r;
      r = '0;
      case (a)
         // Port data registers: bit and byte, zero at reset
         SSD_OFS_PORT_DATA_0: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_PORT_DATA_1: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_PORT_DATA_3: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_PORT_DATA_6: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_PORT_DATA_12: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);

         // USB data windows: byte only, no defined reset content
         SSD_OFS_USB_CTRL_EP_READ_FIFO: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_UNDEF);
         SSD_OFS_USB_BULK_OUT_FIFO: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_UNDEF);
         SSD_OFS_USB_BULK_IN_FIFO: r = ssd_mk(0, 1, 0, 1, 0, SSD_RST_UNDEF);
         SSD_OFS_USB_CTRL_EP_WRITE_FIFO: r = ssd_mk(0, 1, 0, 1, 0, SSD_RST_UNDEF);

         // UART buffers and serial shift: byte only, UART ones at reset, shift zero
         SSD_OFS_UART_RECEIVE_BUFFER: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_UART);
         SSD_OFS_UART_TRANSMIT_BUFFER: r = ssd_mk(1, 1, 0, 1, 0, SSD_RST_UART);
         SSD_OFS_CLOCKED_SERIAL_SHIFT: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);

         // 16-bit timer: word pairs only
         SSD_OFS_TIMER16_COUNT: r = ssd_mk(1, 0, 0, 0, 1, SSD_RST_T16[7:0]);
         SSD_OFS_TIMER16_COUNT + 16'h0001:
            r = ssd_mk(1, 0, 0, 0, 1, SSD_RST_T16[15:8]);
         SSD_OFS_TIMER16_CAPTURE_COMPARE_A:
            r = ssd_mk(1, 1, 0, 0, 1, SSD_RST_T16[7:0]);
         SSD_OFS_TIMER16_CAPTURE_COMPARE_A + 16'h0001:
            r = ssd_mk(1, 1, 0, 0, 1, SSD_RST_T16[15:8]);
         SSD_OFS_TIMER16_CAPTURE_COMPARE_B:
            r = ssd_mk(1, 1, 0, 0, 1, SSD_RST_T16[7:0]);
         SSD_OFS_TIMER16_CAPTURE_COMPARE_B + 16'h0001:
            r = ssd_mk(1, 1, 0, 0, 1, SSD_RST_T16[15:8]);

         // 8-bit timers and compare registers
         SSD_OFS_TIMER8_COUNT_A: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_TIMER8_COMPARE_A: r = ssd_mk(1, 1, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_TIMER_H_COMPARE_LOW: r = ssd_mk(1, 1, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_TIMER_H_COMPARE_HIGH: r = ssd_mk(1, 1, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_TIMER8_COUNT_B: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);

         // USB setup, status and mode registers
         SSD_OFS_USB_SETUP_PACKET_READ: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_INT_STATUS_0: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_INT_STATUS_1: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_INT_STATUS_2: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_INT_STATUS_3: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_INT_STATUS_4: r = ssd_mk(1, 0, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_GENERAL_PURPOSE: r = ssd_mk(1, 1, 0, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_MODE_CONTROL: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_USB_MODE_FLAGS: r = ssd_mk(1, 0, 1, 1, 0, SSD_RST_ZERO);

         // Port direction registers: ones at reset
         SSD_OFS_PORT_DIRECTION_0: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_DIR);
         SSD_OFS_PORT_DIRECTION_1: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_DIR);
         SSD_OFS_PORT_DIRECTION_3: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_DIR);
         SSD_OFS_PORT_DIRECTION_6: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_DIR);
         SSD_OFS_PORT_DIRECTION_12: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_DIR);

         // Pull-up option registers
         SSD_OFS_PULLUP_ENABLE_0: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         SSD_OFS_PULLUP_ENABLE_1: r = ssd_mk(1, 1, 1, 1, 0, SSD_RST_ZERO);
         default: r = '0;
      endcase
      return r;
   endfunction

   // Reset value of one byte address
   function automatic logic [7:0] ssd_rst_of(input logic [15:0] a);
      ssd_attr_s t;
      t = ssd_lookup(a);
      return t.rst;
   endfunction

   // Value a read of one slot returns: stored if read-write, peripheral's if read-only, else zero
   function automatic logic [7:0] ssd_byte_read(
      input ssd_attr_s a,
      input logic [7:0] stored,
      input logic [7:0] live
   );
      logic [7:0] v;
      v = SSD_RDATA_UNSPEC;
      if (a.rd && a.wr) begin
         v = stored;
      end else if (a.rd) begin
         v = live;
      end
      return v;
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   ssd_chk_if chk_bus ();

   // Stored bytes and answer registers
   logic [7:0] stor_reg [SSD_SLOTS];
   logic ack_reg;
   logic err_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   // Per-slot strobes
   logic [SSD_SLOTS-1:0] wr_stb_reg;
   logic [SSD_SLOTS-1:0] rd_stb_reg;
   logic [SSD_SLOTS-1:0] stb_lo;
   logic [SSD_SLOTS-1:0] stb_hi;

   // Request verdict and byte helpers
   logic go;
   logic lo_valid;
   logic hi_valid;
   logic [7:0] rd_lo;
   logic [7:0] rd_hi;
   logic [7:0] bit_merge;

   // ****************************************************************
   // Access check
   // ****************************************************************

   // Present the request and both byte attributes to the checker
   always_comb begin
      chk_bus.addr = cpu_addr;
      chk_bus.width = cpu_width;
      chk_bus.write = cpu_write;
      chk_bus.attr_lo = ssd_lookup(cpu_addr);
      chk_bus.attr_hi = ssd_lookup(cpu_addr + 16'h0001);
   end

   ssd_access_check u_check (
      .chk(chk_bus.chk)
   );

   // Accepted request this cycle
   always_comb begin
      go = cpu_req && chk_bus.allowed;
   end

   // Slots that index the table; guards every array access below
   always_comb begin
      lo_valid = int'(chk_bus.slot_lo) < SSD_SLOTS;
      hi_valid = int'(chk_bus.slot_hi) < SSD_SLOTS;
   end

   // ****************************************************************
   // Register storage
   // ****************************************************************

   // Merge one bit into the addressed byte for bit writes
   always_comb begin
      bit_merge = lo_valid ? stor_reg[chk_bus.slot_lo] : 8'h00;
      bit_merge[cpu_bit] = cpu_wdata[0];
   end

   // Stored bytes: reset values, then accepted writes only
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < SSD_SLOTS; i++) begin
            stor_reg[i] <= ssd_rst_of(SSD_REGION_BASE + 16'(i));
         end
      end else if (go && cpu_write && lo_valid) begin
         case (cpu_width)
            SSD_W_BIT: stor_reg[chk_bus.slot_lo] <= bit_merge;
            SSD_W_BYTE: stor_reg[chk_bus.slot_lo] <= cpu_wdata[7:0];
            SSD_W_WORD: begin
               stor_reg[chk_bus.slot_lo] <= cpu_wdata[7:0];
               if (hi_valid) begin
                  stor_reg[chk_bus.slot_hi] <= cpu_wdata[15:8];
               end
            end
            default: stor_reg[chk_bus.slot_lo] <= stor_reg[chk_bus.slot_lo];
         endcase
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   // Assemble read data for the accepted width
   always_comb begin
      rd_lo = SSD_RDATA_UNSPEC;
      rd_hi = SSD_RDATA_UNSPEC;
      if (lo_valid) begin
         rd_lo = ssd_byte_read(chk_bus.attr_lo, stor_reg[chk_bus.slot_lo],
            periph_val[chk_bus.slot_lo]);
      end
      if (hi_valid) begin
         rd_hi = ssd_byte_read(chk_bus.attr_hi, stor_reg[chk_bus.slot_hi],
            periph_val[chk_bus.slot_hi]);
      end
      rdata_next = 16'h0000;
      if (go && !cpu_write) begin
         case (cpu_width)
            SSD_W_BIT: rdata_next = {15'h0000, rd_lo[cpu_bit]};
            SSD_W_BYTE: rdata_next = {8'h00, rd_lo};
            SSD_W_WORD: rdata_next = {rd_hi, rd_lo};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // Per-slot strobes for the low and high byte touched
   always_comb begin
      stb_lo = '0;
      stb_hi = '0;
      if (lo_valid) begin
         stb_lo[chk_bus.slot_lo] = 1'b1;
      end
      if (hi_valid && cpu_width == SSD_W_WORD) begin
         stb_hi[chk_bus.slot_hi] = 1'b1;
      end
   end

   // ****************************************************************
   // Answer and strobes
   // ****************************************************************

   // Answer one cycle after every request
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= cpu_req;
      end
   end

   // Refused requests flag an error alongside the answer
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         err_reg <= 1'b0;
      end else begin
         err_reg <= cpu_req && !chk_bus.allowed;
      end
   end

   // Read data held until the next answer; refused reads give zero
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdata_reg <= 16'h0000;
      end else if (cpu_req) begin
         rdata_reg <= rdata_next;
      end
   end

   // Write strobes toward the owning peripherals
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wr_stb_reg <= '0;
      end else begin
         wr_stb_reg <= (go && cpu_write) ? (stb_lo | stb_hi) : '0;
      end
   end

   // Read strobes toward the owning peripherals
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rd_stb_reg <= '0;
      end else begin
         rd_stb_reg <= (go && !cpu_write) ? (stb_lo | stb_hi) : '0;
      end
   end

   // Outputs
   assign cpu_ack = ack_reg;
   assign cpu_err = err_reg;
   assign cpu_rdata = rdata_reg;
   assign sfr_value = stor_reg;
   assign sfr_wr_stb = wr_stb_reg;
   assign sfr_rd_stb = rd_stb_reg;
endmodule

// [tb/ssd_top_assertions.sv]
/*
 * Checker for the decoder top: verdicts, strobes and read data.
 * Assumes it is bound to ssd_top and sees only its ports.
 */
`timescale 1ns/1ps
module ssd_top_assertions (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire ssd_pkg::ssd_width_e cpu_width,
   input wire logic [15:0] cpu_addr,
   input wire logic [2:0] cpu_bit,
   input wire logic [15:0] cpu_wdata,
   input wire logic cpu_ack,
   input wire logic cpu_err,
   input wire logic [15:0] cpu_rdata,
   input wire logic [7:0] periph_val [ssd_pkg::SSD_SLOTS],
   input wire logic [7:0] sfr_value [ssd_pkg::SSD_SLOTS],
   input wire logic [ssd_pkg::SSD_SLOTS-1:0] sfr_wr_stb,
   input wire logic [ssd_pkg::SSD_SLOTS-1:0] sfr_rd_stb
);
   import ssd_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // Answer shapes one cycle after the request
   sequence s_refused;
      cpu_ack && cpu_err && cpu_rdata == 16'h0000;
   endsequence
   sequence s_granted;
      cpu_ack && !cpu_err;
   endsequence

   AST_ACK_NEXT: assert property (cpu_req |=> cpu_ack)
      else $error("no answer one cycle after request");
   AST_ACK_ONLY: assert property (!cpu_req |=> !cpu_ack)
      else $error("answer without request");
   AST_REGION: assert property (cpu_req && (cpu_addr < SSD_REGION_BASE ||
      cpu_addr > 16'hFF31) |=> s_refused) else $error("outside access not refused");
   AST_ODD_WORD: assert property (cpu_req && cpu_width == SSD_W_WORD &&
      cpu_addr[0] |=> s_refused) else $error("odd word access not refused");
   AST_T16_ONLY_WORD: assert property (cpu_req && cpu_width != SSD_W_WORD &&
      cpu_addr inside {[16'hFF10:16'hFF15]} |=> s_refused) else $error("timer narrow access");
   AST_RO_WRITE: assert property (cpu_req && cpu_write && cpu_addr inside
      {16'hFF02, 16'hFF0A, 16'hFF0D, 16'hFF10} |=> s_refused) else $error("read-only written");
   AST_WO_READ: assert property (cpu_req && !cpu_write &&
      cpu_addr inside {16'hFF0E, 16'hFF19} |=> s_refused) else $error("write-only read");
   AST_UART_BYTE: assert property (cpu_req && cpu_width != SSD_W_BYTE &&
      cpu_addr inside {16'hFF0A, 16'hFF0B} |=> s_refused) else $error("uart non-byte access");
   AST_ERR_QUIET: assert property (cpu_err |-> sfr_wr_stb == '0 && sfr_rd_stb == '0)
      else $error("strobe on refused access");
   AST_T16_READ: assert property (cpu_req && !cpu_write && cpu_width == SSD_W_WORD &&
      cpu_addr == 16'hFF10 |=> s_granted ##0
      cpu_rdata == {$past(periph_val[17]), $past(periph_val[16])} &&
      sfr_rd_stb[17:16] == 2'b11)
      else $error("timer word read wrong");
   AST_DIR_WRITE: assert property (cpu_req && cpu_write && cpu_width == SSD_W_BYTE &&
      cpu_addr == 16'hFF20 |=> s_granted ##0 sfr_wr_stb[32] && $onehot(sfr_wr_stb) &&
      sfr_value[32] == $past(cpu_wdata[7:0])) else $error("direction write wrong");
endmodule

// [tb/ssd_cpu_model.sv]
/*
 * CPU side model: issues one access at a time and returns the answer.
 * Assumes the decoder answers one cycle after the request pulse.
 */
`timescale 1ns/1ps
module ssd_cpu_model (
   input wire logic ref_clk,
   input wire logic cpu_ack,
   input wire logic cpu_err,
   input wire logic [15:0] cpu_rdata,
   output logic cpu_req,
   output logic cpu_write,
   output ssd_pkg::ssd_width_e cpu_width,
   output logic [15:0] cpu_addr,
   output logic [2:0] cpu_bit,
   output logic [15:0] cpu_wdata
);
   import ssd_pkg::*;

   // Idle values at time zero
   initial begin
      cpu_req = 1'b0;
      cpu_write = 1'b0;
      cpu_width = SSD_W_BYTE;
      cpu_addr = 16'h0000;
      cpu_bit = 3'h0;
      cpu_wdata = 16'h0000;
   end

   // One access: pulse, hold qualifiers, take answer at its edge
   task automatic access(input logic w, input ssd_width_e wd, input logic [15:0] a,
         input logic [2:0] b, input logic [15:0] d, output logic [15:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge ref_clk);
      cpu_req <= 1'b1;
      cpu_write <= w;
      cpu_width <= wd; // Width chosen by the caller, refusals expected
      cpu_addr <= a;
      cpu_bit <= b;
      cpu_wdata <= d; // Low byte in [7:0] for the even address
      @(posedge ref_clk);
      cpu_req <= 1'b0;
      @(posedge ref_clk);
      while (cpu_ack !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         n++;
      end
      rd = cpu_rdata;
      er = (n < 8) ? cpu_err : 1'bx;
      cpu_addr <= ~a; // Released lines no longer show the old value
      cpu_wdata <= ~d;
   endtask
endmodule

// [tb/special_register_space_decode_bench.sv]
/*
 * Bench for the decoder: access sequences with expected verdicts and data.
 * Assumes ssd_top, the CPU model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module special_register_space_decode_bench;
   import ssd_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cpu_req, cpu_write, cpu_ack, cpu_err;
   ssd_width_e cpu_width;
   logic [15:0] cpu_addr, cpu_wdata, cpu_rdata;
   logic [2:0] cpu_bit;
   logic [7:0] periph_val [SSD_SLOTS];
   logic [7:0] sfr_value [SSD_SLOTS];
   logic [SSD_SLOTS-1:0] sfr_wr_stb, sfr_rd_stb;
   int errors = 0;
   int checks = 0;

   // Clock of 100 ns period
   always #50 ref_clk = ~ref_clk;

   ssd_cpu_model u_cpu (.ref_clk(ref_clk), .cpu_ack(cpu_ack), .cpu_err(cpu_err),
      .cpu_rdata(cpu_rdata), .cpu_req(cpu_req), .cpu_write(cpu_write),
      .cpu_width(cpu_width), .cpu_addr(cpu_addr), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata));
   ssd_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req), .cpu_write(cpu_write),
      .cpu_width(cpu_width), .cpu_addr(cpu_addr), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata),
      .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata), .periph_val(periph_val),
      .sfr_value(sfr_value), .sfr_wr_stb(sfr_wr_stb), .sfr_rd_stb(sfr_rd_stb));

   // Live peripheral byte pattern per slot
   function automatic logic [7:0] pv(input int s);
      return 8'hA0 ^ s[7:0];
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Access with expected verdict; data compared on reads and refusals
   task automatic op(input logic w, input ssd_width_e wd, input logic [15:0] a,
         input logic [15:0] d, input logic e, input logic [15:0] x);
      logic [15:0] rd;
      logic er;
      u_cpu.access(w, wd, a, 3'h3, d, rd, er);
      chk({15'h0000, er}, {15'h0000, e});
      if (wd == SSD_W_BYTE) rd = {8'h00, rd[7:0]};
      if (wd == SSD_W_BIT) rd = {15'h0000, rd[0]};
      if (!w || e) chk(rd, x);
   endtask

   task automatic summarize;
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      #(3000 * 100);
      errors++;
      summarize();
   end

   initial begin
      for (int i = 0; i < SSD_SLOTS; i++) periph_val[i] = pv(i);
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      chk({8'h00, sfr_value[0]}, 16'h0000);
      chk({8'h00, sfr_value[32]}, 16'h00FF);
      chk({8'h00, sfr_value[11]}, 16'h00FF);
      op(0, SSD_W_BYTE, 16'hFF20, 16'h0000, 0, 16'h00FF);
      op(0, SSD_W_BYTE, 16'hFF0B, 16'h0000, 0, 16'h00FF);
      op(0, SSD_W_BYTE, 16'hFF0A, 16'h0000, 0, {8'h00, pv(10)});
      op(1, SSD_W_BYTE, 16'hFF20, 16'h001A, 0, 16'h0000);
      op(0, SSD_W_BIT, 16'hFF20, 16'h0000, 0, 16'h0001);
      op(1, SSD_W_BIT, 16'hFF00, 16'h0001, 0, 16'h0000);
      op(0, SSD_W_BYTE, 16'hFF00, 16'h0000, 0, 16'h0008);
      op(1, SSD_W_BIT, 16'hFF0B, 16'h0001, 1, 16'h0000);
      op(0, SSD_W_BIT, 16'hFF0A, 16'h0000, 1, 16'h0000);
      op(0, SSD_W_BIT, 16'hFF2D, 16'h0000, 1, 16'h0000);
      op(0, SSD_W_BIT, 16'hFF2E, 16'h0000, 0, 16'h0000);
      op(1, SSD_W_WORD, 16'hFF12, 16'h1234, 0, 16'h0000);
      chk({sfr_value[19], sfr_value[18]}, 16'h1234);
      op(0, SSD_W_WORD, 16'hFF12, 16'h0000, 0, 16'h1234);
      op(0, SSD_W_WORD, 16'hFF13, 16'h0000, 1, 16'h0000);
      op(0, SSD_W_BYTE, 16'hFF12, 16'h0000, 1, 16'h0000);
      op(0, SSD_W_WORD, 16'hFF00, 16'h0000, 1, 16'h0000);
      op(0, SSD_W_WORD, 16'hFF10, 16'h0000, 0, {pv(17), pv(16)});
      op(1, SSD_W_WORD, 16'hFF10, 16'h5555, 1, 16'h0000);
      op(1, SSD_W_BYTE, 16'hFF0A, 16'h0055, 1, 16'h0000);
      op(0, SSD_W_BYTE, 16'hFF0A, 16'h0000, 0, {8'h00, pv(10)});
      op(0, SSD_W_BYTE, 16'hFF0E, 16'h0000, 1, 16'h0000);
      op(1, SSD_W_BYTE, 16'hFF0E, 16'h00C3, 0, 16'h0000);
      chk({8'h00, sfr_value[14]}, 16'h00C3);
      op(0, SSD_W_BYTE, 16'hFF19, 16'h0000, 1, 16'h0000);
      op(1, SSD_W_BYTE, 16'hFF02, 16'h005A, 1, 16'h0000);
      op(0, SSD_W_BYTE, 16'hFF0D, 16'h0000, 0, {8'h00, pv(13)});
      op(0, SSD_W_BYTE, 16'hFEFF, 16'h0000, 1, 16'h0000);
      op(1, SSD_W_BYTE, 16'hFF09, 16'h00AA, 1, 16'h0000);
      op(0, SSD_W_BYTE, 16'hFFFF, 16'h0000, 1, 16'h0000);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      chk({sfr_value[19], sfr_value[18]}, 16'h0000);
      chk({8'h00, sfr_value[32]}, 16'h00FF);
      summarize();
   end
endmodule

bind ssd_top ssd_top_assertions u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req),
   .cpu_write(cpu_write), .cpu_width(cpu_width), .cpu_addr(cpu_addr), .cpu_bit(cpu_bit),
   .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
   .periph_val(periph_val), .sfr_value(sfr_value), .sfr_wr_stb(sfr_wr_stb),
   .sfr_rd_stb(sfr_rd_stb));
